/* File: src/mcd_decoder.sv */
/*
  Microcode command decoder: turns the command field of each accepted
  microinstruction into datapath, interrupt and memory control actions.
  Assumes the sequencer presents one word per mi_valid and holds off
  while mi_stall is high; all inputs are synchronous to core_clk.
*/
`timescale 1ns/1ps
`include "mcd_defines.svh"
module mcd_decoder #(
  parameter int unsigned TICK_CYCLES = `MCD_TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Microinstruction from the sequencer
  input wire logic mi_valid,
  input wire logic [`MCD_CMD_W-1:0] mi_cmd,
  input wire logic [`MCD_SUB_W-1:0] mi_sub,
  input wire logic [3:0] a_field,
  input wire logic [3:0] b_field,
  input wire logic shift_req,
  input wire logic fetch_done,
  output logic mi_stall,
  // Internal data bus
  input wire logic [`MCD_DATA_W-1:0] internal_data_bus,
  // Datapath
  output logic [7:0] priority_level,
  output logic [7:0] priority_level_aop,
  output logic [`MCD_DATA_W-1:0] general_register,
  output logic gpr_load,
  output logic gpr_shift,
  output logic rf_we,
  output logic [3:0] rf_addr_a,
  output logic [3:0] rf_addr_b,
  output logic [`MCD_DATA_W-1:0] cmd_data,
  output logic [`MCD_LC_W-1:0] loop_counter,
  output logic [`MCD_LC_W-1:0] loop_counter_aop,
  output logic round_clr,
  // Interrupt logic
  output logic mapj_block,
  output logic panel_irq_mask,
  output logic dma_int_clr,
  output logic serial_int_clr,
  input wire logic host_int_set,
  input wire logic host_int_ack,
  output logic host_to_cpu_irq,
  output logic cpu_to_host_irq,
  output logic stop_ff,
  output logic clock_ff,
  output logic force_valid,
  output logic [`MCD_UADDR_W-1:0] force_addr,
  // I/O control outputs
  output logic [`MCD_DATA_W-1:0] io_control,
  output logic arbiter_request,
  output logic realtime_int_reset,
  output logic master_clear_enable,
  output logic [3:0] int_enables,
  output logic [2:0] lamps,
  // Host interface registers
  output logic hif_rd,
  output logic hif_wr,
  output logic [`MCD_SUB_W-1:0] hif_sel,
  // Memory access controller
  output logic page_table_wr,
  output logic page_ctrl_ld,
  output logic seg_ld,
  output logic [`MCD_SEG_W-1:0] memory_segment,
  output logic set_semaphore_flag,
  output logic indirect_read_cmd_start,
  output logic indirect_read_cmd_alt
);
  mcd_pkg::mcd_state_t s;
  mcd_pkg::mcd_state_t next_s;
  logic tick;
  logic accept;

  mcd_tick_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  // Words arriving during a stretched cycle are refused
  assign accept = mi_valid && (s.phase == mcd_pkg::MCD_RUN);

  always_comb
  begin
    next_s = s;
    // Strobes last one cycle
    next_s.gpr_load = 1'b0;
    next_s.gpr_shift = 1'b0;
    next_s.rf_we = 1'b0;
    next_s.mapj_block = 1'b0;
    next_s.dma_int_clr = 1'b0;
    next_s.serial_int_clr = 1'b0;
    next_s.page_table_wr = 1'b0;
    next_s.page_ctrl_ld = 1'b0;
    next_s.hif_rd = 1'b0;
    next_s.hif_wr = 1'b0;
    next_s.force_valid = 1'b0;
    next_s.round_clr = 1'b0;
    next_s.seg_ld = 1'b0;
    next_s.sem_set = 1'b0;
    next_s.indirect_read_cmd_start = 1'b0;
    // Stretch countdown
    if (s.phase == mcd_pkg::MCD_STRETCH)
    begin
      if (s.slow_cnt == '0)
        next_s.phase = mcd_pkg::MCD_RUN;
      else
        next_s.slow_cnt = s.slow_cnt - `MCD_SLOW_W'(1);
    end
    // Host-side ack clears cpu_int, set raises host_int; commands below may set cpu_int again and win
    if (host_int_ack)
      next_s.cpu_int = 1'b0;
    if (host_int_set)
      next_s.host_int = 1'b1;
    if (accept)
    begin
      // A-operand copies lag one word behind the registers
      next_s.pil_aop = s.priority_level;
      next_s.lc_aop = s.loop_count;
      next_s.gpr_shift = shift_req && (mi_cmd != `MCD_CMD_LOAD_GENERAL_REGISTER);
      next_s.cmd_data = internal_data_bus;
      case (mi_cmd)
        `MCD_CMD_NONE: ;
        `MCD_CMD_LOAD_PRIORITY_LEVEL:
          next_s.priority_level =
            internal_data_bus[`MCD_PIL_HI:`MCD_PIL_LO];
        `MCD_CMD_LOAD_GENERAL_REGISTER:
        begin
          next_s.general_register = internal_data_bus;
          next_s.gpr_load = 1'b1;
        end
        `MCD_CMD_WRF:
        begin
          next_s.rf_we = 1'b1;
          next_s.rf_addr_a = a_field;
          next_s.rf_addr_b = b_field;
        end
        `MCD_CMD_BLKIRQ: next_s.mapj_block = 1'b1;
        `MCD_CMD_INTCTL:
          case (mi_sub)
            `MCD_SUB_0: next_s.dma_int_clr = 1'b1;
            `MCD_SUB_1: next_s.serial_int_clr = 1'b1;
            `MCD_SUB_2: next_s.host_int = host_int_set;
            default: next_s.cpu_int = 1'b1;
          endcase
        `MCD_CMD_HOSTPG:
          case (mi_sub)
            `MCD_SUB_0: next_s.host_int = 1'b1;
            `MCD_SUB_1: next_s.page_table_wr = 1'b1;
            `MCD_SUB_3: next_s.page_ctrl_ld = 1'b1;
            default: ;
          endcase
        `MCD_CMD_LOAD_IO_CONTROL: next_s.io_control = internal_data_bus;
        `MCD_CMD_SLOW:
        begin
          // Whole cycle is SLOW_CYC clocks: this one plus the stall
          next_s.phase = mcd_pkg::MCD_STRETCH;
          next_s.slow_cnt = `MCD_SLOW_W'(`MCD_SLOW_CYC - 2);
        end
        `MCD_CMD_HIF_RD:
        begin
          next_s.hif_rd = 1'b1;
          next_s.hif_sel = mi_sub;
        end
        `MCD_CMD_HIF_WR:
        begin
          next_s.hif_wr = 1'b1;
          next_s.hif_sel = mi_sub;
        end
        `MCD_CMD_START: next_s.stop_ff = 1'b0;
        `MCD_CMD_STOP: next_s.stop_ff = 1'b1;
        `MCD_CMD_CLEAR_CLOCK_TICK: next_s.clock_ff = 1'b0;
        `MCD_CMD_CLEAR_ROUNDING_FLAGS: next_s.round_clr = 1'b1;
        `MCD_CMD_LOAD_LOOP_COUNTER:
          next_s.loop_count = internal_data_bus[`MCD_LC_W-1:0];
        `MCD_CMD_LOAD_MEMORY_SEGMENT:
          if (mi_sub == `MCD_SUB_0)
          begin
            next_s.segment = internal_data_bus[`MCD_SEG_W-1:0];
            next_s.seg_ld = 1'b1;
          end
        `MCD_CMD_SEMA:
          if (mi_sub == `MCD_SUB_1)
            next_s.sem_set = 1'b1;
        `MCD_CMD_INDIRECT_READ_CMD:
          if ((mi_sub == `MCD_SUB_0) || (mi_sub == `MCD_SUB_1))
          begin
            next_s.indirect_read_cmd_start = 1'b1;
            next_s.indirect_read_cmd_alt = mi_sub[0];
          end
        default: ;
      endcase
    end
    // Timer tick beats a same-cycle clear
    if (tick)
      next_s.clock_ff = 1'b1;
    // Clock routine outranks the stop routine at a fetch
    if (fetch_done && s.clock_ff)
    begin
      next_s.force_valid = 1'b1;
      next_s.force_addr = `MCD_CLOCK_VEC;
    end
    else if (fetch_done && s.stop_ff)
    begin
      next_s.force_valid = 1'b1;
      next_s.force_addr = `MCD_STOP_VEC;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.io_control <= `MCD_IOC_RESET;
    end
    else
      s <= next_s;
  end

  assign mi_stall = (s.phase == mcd_pkg::MCD_STRETCH);
  assign priority_level = s.priority_level;
  assign priority_level_aop = s.pil_aop;
  assign general_register = s.general_register;
  assign gpr_load = s.gpr_load;
  assign gpr_shift = s.gpr_shift;
  assign rf_we = s.rf_we;
  assign rf_addr_a = s.rf_addr_a;
  assign rf_addr_b = s.rf_addr_b;
  assign cmd_data = s.cmd_data;
  assign loop_counter = s.loop_count;
  assign loop_counter_aop = s.lc_aop;
  assign round_clr = s.round_clr;
  assign mapj_block = s.mapj_block;
  // Panel interrupts leave the test condition together with the block
  assign panel_irq_mask = s.mapj_block;
  assign dma_int_clr = s.dma_int_clr;
  assign serial_int_clr = s.serial_int_clr;
  assign host_to_cpu_irq =
    s.host_int && s.io_control[`MCD_IOC_HOST_EN];
  assign cpu_to_host_irq = s.cpu_int;
  assign stop_ff = s.stop_ff;
  assign clock_ff = s.clock_ff;
  assign force_valid = s.force_valid;
  assign force_addr = s.force_addr;
  assign io_control = s.io_control;
  assign int_enables = {s.io_control[`MCD_IOC_PWRFAIL],
    s.io_control[`MCD_IOC_MEMRANGE], s.io_control[`MCD_IOC_PARITY],
    s.io_control[`MCD_IOC_ZERO]};
  assign arbiter_request = s.io_control[`MCD_IOC_ARB_REQ];
  assign realtime_int_reset = s.io_control[`MCD_IOC_RT_RESET];
  assign lamps = {s.io_control[`MCD_IOC_CONSOLE],
    s.io_control[`MCD_IOC_RUN], s.io_control[`MCD_IOC_SELFTEST]};
  assign master_clear_enable = s.io_control[`MCD_IOC_SELFTEST];
  assign hif_rd = s.hif_rd;
  assign hif_wr = s.hif_wr;
  assign hif_sel = s.hif_sel;
  assign page_table_wr = s.page_table_wr;
  assign page_ctrl_ld = s.page_ctrl_ld;
  assign seg_ld = s.seg_ld;
  assign memory_segment = s.segment;
  assign set_semaphore_flag = s.sem_set;
  assign indirect_read_cmd_start = s.indirect_read_cmd_start;
  assign indirect_read_cmd_alt = s.indirect_read_cmd_alt;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_cmd(logic [`MCD_CMD_W-1:0] c);
    accept && (mi_cmd == c);
  endsequence

  sequence s_pil_load;
    s_cmd(`MCD_CMD_LOAD_PRIORITY_LEVEL) ##1 accept;
  endsequence

  a_pil_two_words: assert property (
    s_pil_load |=> priority_level_aop == $past(internal_data_bus[15:8], 2))
    else $error("priority level not usable two words later");

  a_gpr_no_shift: assert property (
    s_cmd(`MCD_CMD_LOAD_GENERAL_REGISTER) |=> gpr_load && !gpr_shift
      && general_register == $past(internal_data_bus))
    else $error("general register load shifted or missed");

  a_none_quiet: assert property (
    s_cmd(`MCD_CMD_NONE) && !tick && !host_int_set && !host_int_ack
      |=> $stable(io_control) && $stable(stop_ff) && !rf_we && !hif_wr
      && $stable(cpu_to_host_irq) && !page_table_wr && !indirect_read_cmd_start)
    else $error("null command changed state");

  a_slow_stretch: assert property (
    s_cmd(`MCD_CMD_SLOW) |=> (mi_stall throughout (##22 1)) ##1 !mi_stall)
    else $error("slow cycle length wrong");

  a_io_load: assert property (
    s_cmd(`MCD_CMD_LOAD_IO_CONTROL) |=> io_control == $past(internal_data_bus)
      && arbiter_request == $past(internal_data_bus[4]))
    else $error("I/O control load wrong");

  a_stop_force: assert property (
    fetch_done && stop_ff && !clock_ff
      |=> force_valid && force_addr == `MCD_STOP_VEC)
    else $error("stop vector not forced");

  a_clock_tick: assert property (
    tick |=> clock_ff)
    else $error("clock tick not taken");

  // Clock routine wins over stop routine at the same fetch
  a_clock_force: assert property (
    fetch_done && clock_ff |=> force_valid && force_addr == `MCD_CLOCK_VEC)
    else $error("clock vector not forced");

  a_cpu_int_set: assert property (
    accept && mi_cmd == `MCD_CMD_INTCTL && mi_sub == `MCD_SUB_3
      |=> cpu_to_host_irq)
    else $error("CPU-to-host interrupt not raised despite ack");

  a_lc_two_words: assert property (
    s_cmd(`MCD_CMD_LOAD_LOOP_COUNTER) ##1 accept
      |=> loop_counter_aop == $past(internal_data_bus[5:0], 2))
    else $error("loop counter not usable two words later");

  a_sem_pulse: assert property (
    accept && mi_cmd == `MCD_CMD_SEMA && mi_sub == `MCD_SUB_1
      |=> set_semaphore_flag ##1 !set_semaphore_flag)
    else $error("semaphore strobe wrong");

  a_indirect_read_cmd_alt: assert property (
    accept && mi_cmd == `MCD_CMD_INDIRECT_READ_CMD && mi_sub == `MCD_SUB_1
      |=> indirect_read_cmd_start && indirect_read_cmd_alt)
    else $error("indirect read table select wrong");
endmodule // mcd_decoder

/* File: src/mcd_defines.svh */
/*
  Constants of the microcode command decoder: command codes, sub-codes,
  I/O control bit positions, vectors and timing counts.
  Assumes a 50 MHz core clock and octal command numbering shown in hex.
*/
// Summary of operation
// - Command is microword bits 32-36 plus sub-code; one command per word.
// - Command zero does nothing.
// - Priority level loads status upper byte; A-operand sees it two words later.
// - General register load from data bus suppresses a same-word shift.
// - Register file write stores data bus at the A/B selected location.
// - Block mapped-jump interrupts and drop panel from interrupt test.
// - 05 sub 0-3: clear DMA, clear serial, clear host-to-CPU, raise CPU-to-host.
// - 06 sub 0-3: raise host-to-CPU, page table write, nothing, page control.
// - Command 07 loads whole I/O control register in one word.
// - I/O bits 10,9,8,5 enable interrupts; bit 13 enables host-to-CPU.
// - I/O bit 4 drives the CPU request to the I/O arbiter.
// - I/O bit 3 resets the real-time interrupt.
// - I/O bits 2,1 drive lamps; bit 0 self-test lamp and master clear.
// - Slow command stretches the microcycle to about 475 ns.
// - 11 reads, 12 writes the host interface registers by sub-code.
// - Command 13 clears the stop flip-flop.
// - Command 14 sets stop; each later fetch with the clock flip-flop clear forces microaddress 3760.
// - Every 20 ms clock flip-flop sets and forces 3762; command 15 clears it.
// - Command 16 clears all rounding flags incl. double-zero and one-out.
// - Command 17 loads loop counter from bus bits 5:0; usable two words later.
// - Command 20 sub 0 loads segment register giving address bits 16-23.
// - Command 21 sub 1 sets the shared-memory semaphore.
// - Command 22 sub 0/1 starts indirect read via normal/alternative table.
`ifndef MCD_DEFINES_SVH
`define MCD_DEFINES_SVH
`define MCD_CMD_W 5
`define MCD_SUB_W 2
`define MCD_DATA_W 16
`define MCD_UADDR_W 13
`define MCD_CMD_NONE 5'h00
`define MCD_CMD_LOAD_PRIORITY_LEVEL 5'h01
`define MCD_CMD_LOAD_GENERAL_REGISTER 5'h02
`define MCD_CMD_WRF 5'h03
`define MCD_CMD_BLKIRQ 5'h04
`define MCD_CMD_INTCTL 5'h05
`define MCD_CMD_HOSTPG 5'h06
`define MCD_CMD_LOAD_IO_CONTROL 5'h07
`define MCD_CMD_SLOW 5'h08
`define MCD_CMD_HIF_RD 5'h09
`define MCD_CMD_HIF_WR 5'h0A
`define MCD_CMD_START 5'h0B
`define MCD_CMD_STOP 5'h0C
`define MCD_CMD_CLEAR_CLOCK_TICK 5'h0D
`define MCD_CMD_CLEAR_ROUNDING_FLAGS 5'h0E
`define MCD_CMD_LOAD_LOOP_COUNTER 5'h0F
`define MCD_CMD_LOAD_MEMORY_SEGMENT 5'h10
`define MCD_CMD_SEMA 5'h11
`define MCD_CMD_INDIRECT_READ_CMD 5'h12
`define MCD_SUB_0 2'h0
`define MCD_SUB_1 2'h1
`define MCD_SUB_2 2'h2
`define MCD_SUB_3 2'h3
`define MCD_IOC_RESET 16'h0000
`define MCD_IOC_HOST_EN 13
`define MCD_IOC_PWRFAIL 10
`define MCD_IOC_MEMRANGE 9
`define MCD_IOC_PARITY 8
`define MCD_IOC_ZERO 5
`define MCD_IOC_ARB_REQ 4
`define MCD_IOC_RT_RESET 3
`define MCD_IOC_CONSOLE 2
`define MCD_IOC_RUN 1
`define MCD_IOC_SELFTEST 0
`define MCD_PIL_HI 15
`define MCD_PIL_LO 8
`define MCD_LC_W 6
`define MCD_SEG_W 8
`define MCD_STOP_VEC 13'h07F0
`define MCD_CLOCK_VEC 13'h07F2
`define MCD_CLK_NS 20
`define MCD_CLK_MHZ 50
`define MCD_SLOW_NS 475
`define MCD_SLOW_CYC ((`MCD_SLOW_NS + `MCD_CLK_NS - 1) / `MCD_CLK_NS)
`define MCD_SLOW_W 5
`define MCD_TICK_MS 20
`define MCD_TICK_CYC (`MCD_TICK_MS * 1000 * `MCD_CLK_MHZ)
`define MCD_TICK_W 20
`endif

/* File: src/mcd_pkg.sv */
/*
  Types of the microcode command decoder: phase enum and state structs.
  Assumes mcd_defines.svh for all widths but the 8-bit priority level and 4-bit register addresses.
*/
`include "mcd_defines.svh"
package mcd_pkg;
  typedef enum logic [0:0] {
    MCD_RUN = 1'b0,
    MCD_STRETCH = 1'b1
  } mcd_phase_t;

  typedef struct packed {
    logic [`MCD_TICK_W-1:0] count;
    logic tick;
  } mcd_timer_t;

  typedef struct packed {
    mcd_phase_t phase;
    logic [`MCD_SLOW_W-1:0] slow_cnt;
    logic [7:0] priority_level;
    logic [7:0] pil_aop;
    logic [`MCD_LC_W-1:0] loop_count;
    logic [`MCD_LC_W-1:0] lc_aop;
    logic [`MCD_DATA_W-1:0] general_register;
    logic [`MCD_DATA_W-1:0] cmd_data;
    logic [`MCD_DATA_W-1:0] io_control;
    logic [`MCD_SEG_W-1:0] segment;
    logic [3:0] rf_addr_a;
    logic [3:0] rf_addr_b;
    logic [`MCD_SUB_W-1:0] hif_sel;
    logic [`MCD_UADDR_W-1:0] force_addr;
    logic gpr_load;
    logic gpr_shift;
    logic rf_we;
    logic mapj_block;
    logic dma_int_clr;
    logic serial_int_clr;
    logic host_int;
    logic cpu_int;
    logic page_table_wr;
    logic page_ctrl_ld;
    logic hif_rd;
    logic hif_wr;
    logic stop_ff;
    logic clock_ff;
    logic force_valid;
    logic round_clr;
    logic seg_ld;
    logic sem_set;
    logic indirect_read_cmd_start;
    logic indirect_read_cmd_alt;
  } mcd_state_t;
endpackage

/* File: src/mcd_tick_timer.sv */
/*
  Real-time tick divider: one-cycle tick every TICK_CYCLES core clocks.
  Assumes a free-running core clock and synchronous reset.
*/
`timescale 1ns/1ps
`include "mcd_defines.svh"
module mcd_tick_timer #(
  parameter int unsigned TICK_CYCLES = `MCD_TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Tick out
  output logic tick
);
  mcd_pkg::mcd_timer_t s;
  mcd_pkg::mcd_timer_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count == `MCD_TICK_W'(TICK_CYCLES - 1))
    begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.count = s.count + `MCD_TICK_W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;
endmodule // mcd_tick_timer

/* File: test/mcd_seq_model.sv */
/*
  Microsequencer model: presents one microword at a time, held until the
  decoder takes it. Assumes the decoder stalls words with mi_stall.
*/
`timescale 1ns/1ps
`include "mcd_defines.svh"
module mcd_seq_model (
  // Clock and handshake
  input wire logic core_clk,
  input wire logic mi_stall,
  // Microword out
  output logic mi_valid,
  output logic [`MCD_CMD_W-1:0] mi_cmd,
  output logic [`MCD_SUB_W-1:0] mi_sub,
  output logic [3:0] a_field,
  output logic [3:0] b_field,
  output logic shift_req,
  output logic fetch_done,
  output logic [`MCD_DATA_W-1:0] internal_data_bus
);
  initial
  begin
    mi_valid = 1'h0;
    mi_cmd = 5'h00;
    mi_sub = 2'h0;
    a_field = 4'h0;
    b_field = 4'h0;
    shift_req = 1'h0;
    fetch_done = 1'h0;
    internal_data_bus = 16'h0000;
  end

  // Bus shows the inverse once released, so stale data never matches
  task automatic issue(input logic [4:0] c, input logic [1:0] s,
      input logic [15:0] d, input logic [3:0] a, input logic sh);
    int n;
    n = 0;
    @(posedge core_clk);
    mi_valid <= 1'h1;
    mi_cmd <= c;
    mi_sub <= s;
    a_field <= a;
    b_field <= ~a;
    shift_req <= sh;
    internal_data_bus <= d;
    @(negedge core_clk);
    while (mi_stall !== 1'h0 && n < 200)
    begin
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    mi_valid <= 1'h0;
    internal_data_bus <= ~d;
  endtask

  task automatic fetch();
    @(posedge core_clk);
    fetch_done <= 1'h1;
    @(posedge core_clk);
    fetch_done <= 1'h0;
  endtask
endmodule // mcd_seq_model

/* File: test/test_microcode_command_decoder.sv */
/*
  Self-checking bench of the command decoder, driven through the
  sequencer model. Assumes a short tick divider set by TICK.
*/
`timescale 1ns/1ps
`include "mcd_defines.svh"
module test_microcode_command_decoder;
  localparam int TICK = 400;
  localparam int LIMIT = 3000;
  logic core_clk, rst, host_int_set, host_int_ack, mi_valid, shift_req;
  logic fetch_done, mi_stall, gpr_load, gpr_shift, rf_we, round_clr;
  logic mapj_block, panel_irq_mask, dma_int_clr, serial_int_clr;
  logic host_to_cpu_irq, cpu_to_host_irq, stop_ff, clock_ff, force_valid;
  logic arbiter_request, realtime_int_reset, master_clear_enable;
  logic hif_rd, hif_wr, page_table_wr, page_ctrl_ld, seg_ld;
  logic set_semaphore_flag, indirect_read_cmd_start, indirect_read_cmd_alt;
  logic [1:0] mi_sub, hif_sel;
  logic [2:0] lamps;
  logic [3:0] a_field, b_field, rf_addr_a, rf_addr_b, int_enables;
  logic [4:0] mi_cmd;
  logic [5:0] loop_counter, loop_counter_aop;
  logic [7:0] priority_level, priority_level_aop, memory_segment;
  logic [12:0] force_addr;
  logic [15:0] internal_data_bus, general_register, cmd_data, io_control;
  logic [15:0] pv;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n, t1;
  // Command, sub-code, expected pulse vector
  localparam logic [22:0] TBL [17] = '{
    {5'h00, 2'h0, 16'h0000},
    {5'h02, 2'h0, 16'h4000},
    {5'h03, 2'h0, 16'h2000},
    {5'h04, 2'h0, 16'h1800},
    {5'h05, 2'h0, 16'h0400},
    {5'h05, 2'h1, 16'h0200},
    {5'h06, 2'h1, 16'h0100},
    {5'h06, 2'h3, 16'h0080},
    {5'h06, 2'h2, 16'h0000},
    {5'h0E, 2'h0, 16'h0010},
    {5'h10, 2'h0, 16'h0008},
    {5'h10, 2'h2, 16'h0000},
    {5'h11, 2'h1, 16'h0004},
    {5'h11, 2'h3, 16'h0000},
    {5'h12, 2'h0, 16'h0002},
    {5'h12, 2'h3, 16'h0000},
    {5'h1F, 2'h0, 16'h0000}};

  assign pv = {1'h0, gpr_load, rf_we, mapj_block, panel_irq_mask,
    dma_int_clr, serial_int_clr, page_table_wr, page_ctrl_ld, hif_rd,
    hif_wr, round_clr, seg_ld, set_semaphore_flag, indirect_read_cmd_start,
    force_valid};

  mcd_seq_model SEQ (.core_clk, .mi_stall, .mi_valid, .mi_cmd, .mi_sub,
    .a_field, .b_field, .shift_req, .fetch_done, .internal_data_bus);

  mcd_decoder #(.TICK_CYCLES(TICK)) DUT (.core_clk, .rst, .mi_valid,
    .mi_cmd, .mi_sub, .a_field, .b_field, .shift_req, .fetch_done,
    .mi_stall, .internal_data_bus, .priority_level, .priority_level_aop,
    .general_register, .gpr_load, .gpr_shift, .rf_we, .rf_addr_a,
    .rf_addr_b, .cmd_data, .loop_counter, .loop_counter_aop, .round_clr,
    .mapj_block, .panel_irq_mask, .dma_int_clr, .serial_int_clr,
    .host_int_set, .host_int_ack, .host_to_cpu_irq, .cpu_to_host_irq,
    .stop_ff, .clock_ff, .force_valid, .force_addr, .io_control,
    .arbiter_request, .realtime_int_reset, .master_clear_enable,
    .int_enables, .lamps, .hif_rd, .hif_wr, .hif_sel, .page_table_wr,
    .page_ctrl_ld, .seg_ld, .memory_segment, .set_semaphore_flag,
    .indirect_read_cmd_start, .indirect_read_cmd_alt);

  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard: the whole run needs well under LIMIT cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles >= LIMIT)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One accepted word, then look at the cycle its pulses stand in
  task automatic cmd(input logic [4:0] c, input logic [1:0] s,
      input logic [15:0] d);
    SEQ.issue(c, s, d, 4'h3, 1'h0);
    @(negedge core_clk);
  endtask

  task automatic wait_tick();
    n = 0;
    while (clock_ff !== 1'h1 && n < 2 * TICK)
    begin
      n++;
      @(negedge core_clk);
    end
  endtask

  initial
  begin
    rst = 1'h1;
    host_int_set = 1'h0;
    host_int_ack = 1'h0;
    repeat (5) @(posedge core_clk);
    rst <= 1'h0;
    @(negedge core_clk);
    chk("io_control reset", io_control, 16'h0000);
    chk("stall reset", 16'(mi_stall), 16'h0000);
    cmd(5'h0C, 2'h0, 16'h0000);
    chk("stop_ff set", 16'(stop_ff), 16'h0001);
    SEQ.fetch();
    @(negedge core_clk);
    chk("stop vector", 16'({force_valid, force_addr}), 16'h27F0);
    cmd(5'h0B, 2'h0, 16'h0000);
    chk("stop_ff clear", 16'(stop_ff), 16'h0000);
    SEQ.fetch();
    @(negedge core_clk);
    chk("no force", 16'(force_valid), 16'h0000);
    cmd(5'h07, 2'h0, 16'h2519);
    chk("io_control", io_control, 16'h2519);
    chk("int_enables", 16'(int_enables), 16'h000A);
    chk("arbiter", 16'(arbiter_request), 16'h0001);
    chk("rt reset", 16'(realtime_int_reset), 16'h0001);
    chk("lamps", 16'({lamps, master_clear_enable}), 16'h0003);
    cmd(5'h06, 2'h0, 16'h0000);
    chk("host irq set", 16'(host_to_cpu_irq), 16'h0001);
    cmd(5'h05, 2'h2, 16'h0000);
    chk("host irq clr", 16'(host_to_cpu_irq), 16'h0000);
    @(posedge core_clk);
    host_int_set <= 1'h1;
    @(posedge core_clk);
    host_int_set <= 1'h0;
    cmd(5'h07, 2'h0, 16'h0519);
    chk("host irq masked", 16'(host_to_cpu_irq), 16'h0000);
    cmd(5'h05, 2'h3, 16'h0000);
    chk("cpu irq set", 16'(cpu_to_host_irq), 16'h0001);
    @(posedge core_clk);
    host_int_ack <= 1'h1;
    @(posedge core_clk);
    host_int_ack <= 1'h0;
    @(negedge core_clk);
    chk("cpu irq ack", 16'(cpu_to_host_irq), 16'h0000);
    cmd(5'h01, 2'h0, 16'hAB00);
    chk("level", 16'({priority_level, priority_level_aop}), 16'hAB00);
    cmd(5'h00, 2'h0, 16'h1100);
    chk("level aop", 16'(priority_level_aop), 16'h00AB);
    cmd(5'h0F, 2'h0, 16'hFFE5);
    chk("loop", 16'({loop_counter, loop_counter_aop}), 16'h0940);
    cmd(5'h00, 2'h0, 16'h0000);
    chk("loop aop", 16'(loop_counter_aop), 16'h0025);
    SEQ.issue(5'h02, 2'h0, 16'hC3A5, 4'h6, 1'h1);
    @(negedge core_clk);
    chk("gpr", general_register, 16'hC3A5);
    chk("gpr no shift", 16'({gpr_load, gpr_shift}), 16'h0002);
    SEQ.issue(5'h03, 2'h0, 16'hBEEF, 4'h6, 1'h1);
    @(negedge core_clk);
    chk("rf addr", 16'({rf_we, rf_addr_a, rf_addr_b}), 16'h0169);
    chk("rf data", cmd_data, 16'hBEEF);
    chk("shift kept", 16'(gpr_shift), 16'h0001);
    for (int i = 0; i < 17; i++)
    begin
      cmd(TBL[i][22:18], TBL[i][17:16], 16'h5A5A);
      chk("pulses", pv, TBL[i][15:0]);
    end
    chk("segment", 16'(memory_segment), 16'h005A);
    chk("io kept", io_control, 16'h0519);
    chk("level kept", 16'(priority_level), 16'h00AB);
    chk("alt normal", 16'(indirect_read_cmd_alt), 16'h0000);
    cmd(5'h12, 2'h1, 16'h0000);
    chk("alt table", 16'({indirect_read_cmd_start, indirect_read_cmd_alt}), 16'h0003);
    for (int s = 0; s < 4; s++)
    begin
      cmd(5'h09, 2'(s), 16'h0000);
      chk("hif rd", {pv[6], 13'h0, hif_sel}, {3'h4, 11'h0, 2'(s)});
      cmd(5'h0A, 2'(s), 16'h0000);
      chk("hif wr", {pv[5], 13'h0, hif_sel}, {3'h4, 11'h0, 2'(s)});
    end
    cmd(5'h08, 2'h0, 16'h0000);
    n = 0;
    while (mi_stall === 1'h1 && n < 40)
    begin
      n++;
      @(negedge core_clk);
    end
    chk("stall cycles", 16'(n), 16'(`MCD_SLOW_CYC - 1));
    wait_tick();
    t1 = cycles;
    SEQ.fetch();
    @(negedge core_clk);
    chk("clock vector", 16'({force_valid, force_addr}), 16'h27F2);
    cmd(5'h0D, 2'h0, 16'h0000);
    chk("clock clear", 16'(clock_ff), 16'h0000);
    wait_tick();
    chk("tick period", 16'(cycles - t1), 16'(TICK));
    print_verdict();
  end
endmodule // test_microcode_command_decoder
